/* File: logic/dtrim_params.svh */
/*
 * Register offsets, field widths and reset values for the detector and
 * reference trim register bank.
 * Assumes byte addressing over a 32-bit AXI4-Lite bus; the printed
 * offsets are register indices and the byte address is four times one.
 */
`ifndef DTRIM_PARAMS_SVH
`define DTRIM_PARAMS_SVH

`define DTRIM_IDX_THRESH 6'h10
`define DTRIM_IDX_HYST 6'h11
`define DTRIM_IDX_VREF 6'h12
`define DTRIM_IDX_REF_CURRENT_TRIM 6'h13
`define DTRIM_IDX_OSC 6'h14
`define DTRIM_IDX_SUPPLY 6'h17
`define DTRIM_IDX_STATUS 6'h1F

`define DTRIM_W_THRESH 4
`define DTRIM_W_HYST 3
`define DTRIM_W_VREF 3
`define DTRIM_W_REF_CURRENT_TRIM 4
`define DTRIM_W_OSC 4
`define DTRIM_POS_SUPPLY 3

`define DTRIM_RST_THRESH 4'h0
`define DTRIM_RST_HYST 3'h0
`define DTRIM_RST_VREF 3'h0
`define DTRIM_RST_REF_CURRENT_TRIM 4'h0
`define DTRIM_RST_OSC 4'h0
`define DTRIM_RST_SUPPLY 1'h0

`define DTRIM_RESP_OKAY 2'h0
`define DTRIM_RESP_SLVERR 2'h2

`endif

/* File: logic/dtrim_pkg.sv */
/*
 * Types used by the trim register bank; its register store does not use them.
 * Assumes nothing of its surroundings.
 */
package dtrim_pkg;

    typedef enum logic [1:0] {
        DTRIM_WR_IDLE = 2'b00,
        DTRIM_WR_RESP = 2'b01
    } dtrim_wr_state_t;

    typedef enum logic [5:0] {
        DTRIM_SEL_THRESH = 6'h10,
        DTRIM_SEL_HYST = 6'h11,
        DTRIM_SEL_VREF = 6'h12,
        DTRIM_SEL_REF_CURRENT_TRIM = 6'h13,
        DTRIM_SEL_OSC = 6'h14
    } dtrim_sel_t;

endpackage : dtrim_pkg

/* File: logic/dtrim_wr_if.sv */
/*
 * Write port from the bus slave into the trim register store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface dtrim_wr_if;
    logic wrEn;
    logic [5:0] wrIdx;
    logic [7:0] wrData;

    modport master (output wrEn, output wrIdx, output wrData);
    modport slave (input wrEn, input wrIdx, input wrData);
endinterface : dtrim_wr_if

/* File: logic/dtrim_store.sv */
/*
 * Register store holding every trim field and the supply-select bit.
 * Assumes writes arrive as single-cycle strobes on the write interface,
 * synchronous active-high reset on the same clock.
 */
`timescale 1ns/1ps
`include "dtrim_params.svh"

module dtrim_store (
    input wire logic mclk,
    input wire logic rst,
    dtrim_wr_if.slave wr,
    output logic [3:0] thresholdCode,
    output logic [2:0] hysteresisCode,
    output logic [2:0] vrefTrimCode,
    output logic [3:0] irefTrimCode,
    output logic [3:0] oscTrimCode,
    output logic supplySelectBit
);

    ////////////////////////////////////////////////////////////////////////
    wire logic hitThresh = wr.wrEn && wr.wrIdx == `DTRIM_IDX_THRESH;
    wire logic hitHyst = wr.wrEn && wr.wrIdx == `DTRIM_IDX_HYST;
    wire logic hitVref = wr.wrEn && wr.wrIdx == `DTRIM_IDX_VREF;
    wire logic hitIref = wr.wrEn && wr.wrIdx == `DTRIM_IDX_REF_CURRENT_TRIM;
    wire logic hitOsc = wr.wrEn && wr.wrIdx == `DTRIM_IDX_OSC;
    wire logic hitSupply = wr.wrEn && wr.wrIdx == `DTRIM_IDX_SUPPLY;

    // Codes are stored as written; forbidden codes are the writer's duty,
    // so the analog side sees exactly what software put there.
    always_ff @(posedge mclk) begin
        if (rst) begin
            thresholdCode <= `DTRIM_RST_THRESH;
            hysteresisCode <= `DTRIM_RST_HYST;
            vrefTrimCode <= `DTRIM_RST_VREF;
            irefTrimCode <= `DTRIM_RST_REF_CURRENT_TRIM;
            oscTrimCode <= `DTRIM_RST_OSC;
            supplySelectBit <= `DTRIM_RST_SUPPLY;
        end else begin
            if (hitThresh) thresholdCode <= wr.wrData[3:0];
            if (hitHyst) hysteresisCode <= wr.wrData[2:0];
            if (hitVref) vrefTrimCode <= wr.wrData[2:0];
            if (hitIref) irefTrimCode <= wr.wrData[3:0];
            if (hitOsc) oscTrimCode <= wr.wrData[3:0];
            if (hitSupply) begin
                supplySelectBit <= wr.wrData[`DTRIM_POS_SUPPLY];
            end
        end
    end

endmodule : dtrim_store

/* File: logic/detector_and_reference_trim_regs.sv */
/*
 * AXI4-Lite register bank for the pressure detector threshold and
 * hysteresis, the reference voltage and current trims, the oscillator
 * trim and the supply-select bit. Each code drives an analog control
 * pin from a flip-flop.
 * Assumes a single clock mclk at 100 MHz and synchronous active-high rst.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dtrim_params.svh"

module detector_and_reference_trim_regs #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] thresholdCode,
    output logic [2:0] hysteresisCode,
    output logic [2:0] vrefTrimCode,
    output logic [3:0] irefTrimCode,
    output logic [3:0] oscTrimCode,
    output logic supplySelectBit,
    output logic lowSupplyThreshFault,
    output logic oscCodeFault
);

    // The index is cut from address bits 7:2, so a narrower bus cannot
    // reach the map at all.
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_addr_width_check
        $error("ADDR_WIDTH must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are latched in either order, then
    // the store is written once and the response is raised.
    dtrim_pkg::dtrim_wr_state_t wrState;
    logic awHeld;
    logic wHeld;
    logic [5:0] awIdx;
    logic awBad;
    logic [7:0] wByte;
    logic wLaneOk;

    wire logic awFire = s_axi_awvalid && s_axi_awready;
    wire logic wFire = s_axi_wvalid && s_axi_wready;
    wire logic [5:0] awIdxIn = s_axi_awaddr[7:2];
    wire logic awBadIn = (s_axi_awaddr[1:0] != 2'h0)
        || (ADDR_WIDTH > 8 && (s_axi_awaddr >> 8) != '0);
    wire logic bothHeld = awHeld && wHeld;
    wire logic awMapped = awIdx == `DTRIM_IDX_THRESH
        || awIdx == `DTRIM_IDX_HYST || awIdx == `DTRIM_IDX_VREF
        || awIdx == `DTRIM_IDX_REF_CURRENT_TRIM || awIdx == `DTRIM_IDX_OSC
        || awIdx == `DTRIM_IDX_SUPPLY;
    wire logic wrOk = awMapped && !awBad;
    wire logic doWrite = bothHeld && wrState == dtrim_pkg::DTRIM_WR_IDLE
        && wrOk && wLaneOk;

    dtrim_wr_if wrBus ();
    assign wrBus.wrEn = doWrite;
    assign wrBus.wrIdx = awIdx;
    assign wrBus.wrData = wByte;

    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awIdx <= 6'h00;
            awBad <= 1'b0;
        end else if (awFire) begin
            awHeld <= 1'b1;
            awIdx <= awIdxIn;
            awBad <= awBadIn;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awHeld <= 1'b0;
        end
    end

    // Only byte lane 0 carries data; a write without it changes nothing.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wByte <= 8'h00;
            wLaneOk <= 1'b0;
        end else if (wFire) begin
            wHeld <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLaneOk <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld && !awFire && !s_axi_awready;
            s_axi_wready <= !wHeld && !wFire && !s_axi_wready;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrState <= dtrim_pkg::DTRIM_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DTRIM_RESP_OKAY;
        end else begin
            unique case (wrState)
                dtrim_pkg::DTRIM_WR_IDLE: begin
                    if (bothHeld) begin
                        wrState <= dtrim_pkg::DTRIM_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wrOk ? `DTRIM_RESP_OKAY
                            : `DTRIM_RESP_SLVERR;
                    end
                end
                dtrim_pkg::DTRIM_WR_RESP: begin
                    if (s_axi_bready) begin
                        wrState <= dtrim_pkg::DTRIM_WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wrState <= dtrim_pkg::DTRIM_WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register store. One code per field feeds both comparators, so the
    // negative-side threshold is mirrored in the analog block, not here.
    dtrim_store store (
        .mclk(mclk),
        .rst(rst),
        .wr(wrBus),
        .thresholdCode(thresholdCode),
        .hysteresisCode(hysteresisCode),
        .vrefTrimCode(vrefTrimCode),
        .irefTrimCode(irefTrimCode),
        .oscTrimCode(oscTrimCode),
        .supplySelectBit(supplySelectBit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, data registered on the same edge
    // that takes the address.
    wire logic arFire = s_axi_arvalid && s_axi_arready;
    wire logic [5:0] arIdx = s_axi_araddr[7:2];
    wire logic arBad = (s_axi_araddr[1:0] != 2'h0)
        || (ADDR_WIDTH > 8 && (s_axi_araddr >> 8) != '0);

    // Flags that show the host has left a forbidden code in place; they
    // are advisory only and never alter the stored code.
    wire logic lowThreshBad = supplySelectBit
        && (thresholdCode == 4'h6 || thresholdCode == 4'h7);
    wire logic oscBad = oscTrimCode >= 4'h5
        && oscTrimCode <= 4'hB;

    // Read decode: one select per register and an AND-OR merge, so an
    // unmapped or misaligned address reads as zero with no priority chain.
    wire logic selThresh = arIdx == `DTRIM_IDX_THRESH;
    wire logic selHyst = arIdx == `DTRIM_IDX_HYST;
    wire logic selVref = arIdx == `DTRIM_IDX_VREF;
    wire logic selIref = arIdx == `DTRIM_IDX_REF_CURRENT_TRIM;
    wire logic selOsc = arIdx == `DTRIM_IDX_OSC;
    wire logic selSupply = arIdx == `DTRIM_IDX_SUPPLY;
    wire logic selStatus = arIdx == `DTRIM_IDX_STATUS;
    wire logic rdHit = !arBad && (selThresh || selHyst || selVref
        || selIref || selOsc || selSupply || selStatus);

    // Each field is zero-extended to a full word before the merge; the supply bit is placed at bit 3.
    wire logic [31:0] wordThresh = {28'h0, thresholdCode};
    wire logic [31:0] wordHyst = {29'h0, hysteresisCode};
    wire logic [31:0] wordVref = {29'h0, vrefTrimCode};
    wire logic [31:0] wordIref = {28'h0, irefTrimCode};
    wire logic [31:0] wordOsc = {28'h0, oscTrimCode};
    wire logic [31:0] wordSupply = 32'(supplySelectBit)
        << `DTRIM_POS_SUPPLY;
    wire logic [31:0] wordStatus = {30'h0, oscBad, lowThreshBad};
    wire logic [31:0] rdMux = {32{rdHit}} & (
        ({32{selThresh}} & wordThresh) | ({32{selHyst}} & wordHyst)
        | ({32{selVref}} & wordVref) | ({32{selIref}} & wordIref)
        | ({32{selOsc}} & wordOsc) | ({32{selSupply}} & wordSupply)
        | ({32{selStatus}} & wordStatus));

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !arFire && !s_axi_arready;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DTRIM_RESP_OKAY;
        end else if (arFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdHit ? `DTRIM_RESP_OKAY : `DTRIM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            lowSupplyThreshFault <= 1'b0;
            oscCodeFault <= 1'b0;
        end else begin
            lowSupplyThreshFault <= lowThreshBad;
            oscCodeFault <= oscBad;
        end
    end

endmodule : detector_and_reference_trim_regs

/* File: verification/dtrim_regs_sva.sv */
/* Checker for the trim register bank ports.
   Assumes it is bound onto the bank's top module. */
`timescale 1ns/1ps
`include "dtrim_params.svh"

module dtrim_regs_sva #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [3:0] thresholdCode,
    input wire logic [2:0] hysteresisCode,
    input wire logic [2:0] vrefTrimCode,
    input wire logic [3:0] irefTrimCode,
    input wire logic [3:0] oscTrimCode,
    input wire logic supplySelectBit,
    input wire logic lowSupplyThreshFault,
    input wire logic oscCodeFault
);
    // Handshake payloads are held so a response can be tied to its cause.
    logic [ADDR_WIDTH-1:0] awHeld;
    logic [ADDR_WIDTH-1:0] arHeld;
    logic [31:0] wHeld;
    logic strobeHeld;
    wire oscBad = oscTrimCode inside {[4'h5:4'hB]};
    always_ff @(posedge mclk) begin
        if (s_axi_awvalid && s_axi_awready) awHeld <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wHeld <= s_axi_wdata;
        if (s_axi_wvalid && s_axi_wready) strobeHeld <= s_axi_wstrb[0];
        if (s_axi_arvalid && s_axi_arready) arHeld <= s_axi_araddr;
    end
////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wr(a);
        $rose(s_axi_bvalid) && s_axi_bresp == `DTRIM_RESP_OKAY
            && strobeHeld && awHeld == a;
    endsequence
    sequence s_rd(a);
        $rose(s_axi_rvalid) && arHeld == a;
    endsequence
    a_thresh_write: assert property (
        s_wr(8'h40) |-> thresholdCode == wHeld[3:0])
        else $error("threshold code differs from written data");
    a_hyst_write: assert property (
        s_wr(8'h44) |-> hysteresisCode == wHeld[2:0])
        else $error("hysteresis code differs from written data");
    a_vref_write: assert property (
        s_wr(8'h48) |-> vrefTrimCode == wHeld[2:0])
        else $error("voltage trim differs from written data");
    a_ref_current_trim_write: assert property (
        s_wr(8'h4C) |-> irefTrimCode == wHeld[3:0])
        else $error("current trim differs from written data");
    a_osc_write: assert property (
        s_wr(8'h50) |-> oscTrimCode == wHeld[3:0])
        else $error("oscillator code differs from written data");
    a_supply_write: assert property (
        s_wr(8'h5C) |-> supplySelectBit == wHeld[3])
        else $error("supply select differs from written data");
    a_codes_quiet: assert property (
        $changed({thresholdCode, hysteresisCode, vrefTrimCode,
        irefTrimCode, oscTrimCode, supplySelectBit})
        |-> $rose(s_axi_bvalid))
        else $error("code changed without a write response");
    a_read_back: assert property (
        s_rd(8'h40) |-> s_axi_rdata == {28'h0, thresholdCode})
        else $error("threshold read back differs");
    a_read_refuse: assert property (
        s_rd(8'h60) |-> s_axi_rresp == `DTRIM_RESP_SLVERR
        && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_low_fault: assert property (
        lowSupplyThreshFault ==
        $past(supplySelectBit && thresholdCode[3:1] == 3'h3))
        else $error("low supply threshold flag wrong");
    a_osc_fault: assert property (
        oscBad && $past(oscBad) |-> oscCodeFault)
        else $error("oscillator code flag missing");
    a_osc_clear: assert property (
        !oscBad && !$past(oscBad) |-> !oscCodeFault)
        else $error("oscillator code flag spurious");
endmodule : dtrim_regs_sva

bind detector_and_reference_trim_regs dtrim_regs_sva #(
    .ADDR_WIDTH(ADDR_WIDTH)
) chk (.*);

/* File: verification/detector_and_reference_trim_regs_test.sv */
/* Self-checking bench for the trim register bank over AXI4-Lite.
   Assumes the bank's top module and its parameter header. */
`timescale 1ns/1ps
`include "dtrim_params.svh"

module detector_and_reference_trim_regs_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, expCodes, seenCodes;
    logic [3:0] thresholdCode, irefTrimCode, oscTrimCode;
    logic [2:0] hysteresisCode, vrefTrimCode;
    logic supplySelectBit, lowSupplyThreshFault, oscCodeFault;
    logic [7:0] adr [6] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h5C};
    logic [31:0] msk [6] = '{32'hF, 32'h7, 32'h7, 32'hF, 32'hF, 32'h8};
    logic [7:0] bad [3] = '{8'h60, 8'h41, 8'h7C};
    int miscompares = 0;
    int samples_checked = 0;

    detector_and_reference_trim_regs #(.ADDR_WIDTH(8)) dut (.*);

    initial forever #5 mclk = ~mclk;
////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic overtime(input logic hung);
        if (hung) begin
            miscompares++;
            give_verdict();
        end
    endtask : overtime

    // Ready is sampled at the falling edge; inputs only move at rising ones.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic ap, wp, ah, wh, bp;
        logic [1:0] r;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b1;
        for (int n = 0; n < 50 && bp; n++) begin
            @(negedge mclk);
            ah = ap && s_axi_awready;
            wh = wp && s_axi_wready;
            bp = !s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            ap = ap && !ah;
            wp = wp && !wh;
        end
        s_axi_bready <= 1'b0;
        overtime(bp);
        check(32'(r), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic ap, ah, rp;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ap = 1'b1;
        rp = 1'b1;
        for (int n = 0; n < 50 && rp; n++) begin
            @(negedge mclk);
            ah = ap && s_axi_arready;
            rp = !s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ah) s_axi_arvalid <= 1'b0;
            ap = ap && !ah;
        end
        s_axi_rready <= 1'b0;
        overtime(rp);
        check(d, ed);
        check(32'(r), 32'(er));
    endtask : rd
////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rd(adr[i], 32'h0, `DTRIM_RESP_OKAY);
        $display("reset value test done");
        for (int i = 0; i < 6; i++) begin
            wr(adr[i], 32'hFFFFFFFF, 4'hF, `DTRIM_RESP_OKAY);
            rd(adr[i], msk[i], `DTRIM_RESP_OKAY);
        end
        wr(8'h40, 32'h3, 4'hE, `DTRIM_RESP_OKAY);
        for (int i = 0; i < 3; i++)
            wr(bad[i], 32'h0, 4'hF, `DTRIM_RESP_SLVERR);
        rd(8'h60, 32'h0, `DTRIM_RESP_SLVERR);
        rd(8'h41, 32'h0, `DTRIM_RESP_SLVERR);
        rd(8'h40, 32'hF, `DTRIM_RESP_OKAY);
        $display("mask and refusal test done");
        // The supply bit is still set, so every code runs at 3 V.
        for (int c = 0; c < 16; c++) begin
            for (int i = 0; i < 5; i++)
                wr(adr[i], 32'(c), 4'hF, `DTRIM_RESP_OKAY);
            @(negedge mclk);
            expCodes = {12'h0, c[3:0], c[2:0], c[2:0], c[3:0], c[3:0],
                c inside {[5:11]}, c == 6 || c == 7};
            seenCodes = {12'h0, thresholdCode, hysteresisCode, vrefTrimCode,
                irefTrimCode, oscTrimCode, oscCodeFault, lowSupplyThreshFault};
            check(seenCodes, expCodes);
            rd(8'h7C, 32'(expCodes[1:0]), `DTRIM_RESP_OKAY);
        end
        wr(8'h40, 32'h7, 4'hF, `DTRIM_RESP_OKAY);
        wr(8'h5C, 32'h0, 4'hF, `DTRIM_RESP_OKAY);
        @(negedge mclk);
        check(32'({supplySelectBit, lowSupplyThreshFault}), 32'h0);
        $display("code sweep test done");
        give_verdict();
    end
endmodule : detector_and_reference_trim_regs_test
